/* hw/vcr_pkg.sv */
// package: offsets, field layout, reset values and timing for the vc0 resource registers
package vcr_pkg;
    localparam int           ADDR_W        = 12;
    localparam int           DATA_W        = 32;

    localparam logic [11:0]  OFF_PORT_VC   = 12'h14c;
    localparam logic [11:0]  OFF_CAP0      = 12'h150;
    localparam logic [11:0]  OFF_CTL0      = 12'h154;

    // port vc word
    localparam int           VCLOAD_BIT    = 0;
    localparam int           VCSEL_LSB     = 1;
    localparam int           VCSEL_W       = 3;
    localparam logic [2:0]   VCSEL_RST     = 3'h0;
    localparam logic [2:0]   VCSEL_MAX_OK  = 3'h1;
    localparam int           VCSTAT_BIT    = 16;

    // vc0 capability word
    localparam int           PACAP_LSB     = 0;
    localparam logic [7:0]   PACAP_RST     = 8'h09;
    localparam int           APS_BIT       = 14;
    localparam int           RSNOOP_BIT    = 15;
    localparam int           MTS_LSB       = 16;
    localparam int           MTS_W         = 7;
    localparam logic [6:0]   MTS_RST       = 7'h7f;
    localparam int           PATOFF_LSB    = 24;
    localparam logic [7:0]   PATOFF_RST    = 8'h04;

    // vc0 control word
    localparam int           TCMAP_LSB     = 0;
    localparam int           TCMAP_W       = 8;
    localparam logic [7:0]   TCMAP_RST     = 8'hff;
    localparam int           PALOAD_BIT    = 16;
    localparam int           PASEL_LSB     = 17;
    localparam int           PASEL_W       = 3;
    localparam logic [2:0]   PASEL_RR      = 3'h0;
    localparam logic [2:0]   PASEL_WRR128  = 3'h3;
    localparam int           VCID_LSB      = 24;
    localparam logic [2:0]   VCID_RST      = 3'h0;
    localparam int           VCEN_BIT      = 31;
    localparam logic         VCEN_RST      = 1'b1;

    // table load time in core cycles
    localparam int           LOAD_CYCLES   = 8;

    typedef enum logic [1:0] {
        VCR_LD_IDLE = 2'b00,
        VCR_LD_BUSY = 2'b01,
        VCR_LD_DONE = 2'b11
    } vcr_ld_e;
endpackage : vcr_pkg

/* hw/vcr_table_loader.sv */
// table load sequencer: strobes the table into hardware and signals completion
`timescale 1ns/1ps
module vcr_table_loader #(
    parameter int CYCLES = vcr_pkg::LOAD_CYCLES
) (
    input  wire logic mclk,
    input  wire logic rst_n,
    input  wire logic start,
    output logic      busy,
    output logic      done
);
    import vcr_pkg::*;

    if (CYCLES < 1 || CYCLES > 255) begin : g_chk
        $error("vcr_table_loader: CYCLES out of range");
    end

    typedef struct packed {
        vcr_ld_e    st;
        logic [7:0] cnt;
        logic       busy;
        logic       done;
    } vcr_ld_s;

    vcr_ld_s r;
    vcr_ld_s next_r;

    always_comb begin
        next_r      = r;
        next_r.done = 1'b0;
        case (r.st)
            VCR_LD_IDLE: begin
                if (start) begin
                    next_r.st   = VCR_LD_BUSY;
                    next_r.cnt  = 8'(CYCLES - 1);
                    next_r.busy = 1'b1;
                end
            end
            VCR_LD_BUSY: begin
                if (r.cnt == 8'h00) begin
                    next_r.st   = VCR_LD_DONE;
                    next_r.busy = 1'b0;
                    next_r.done = 1'b1;
                end else begin
                    next_r.cnt = r.cnt - 8'h01;
                end
            end
            VCR_LD_DONE: begin
                next_r.st = VCR_LD_IDLE;
            end
            default: begin
                next_r.st   = VCR_LD_IDLE;
                next_r.busy = 1'b0;
            end
        endcase
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            r <= '{st: VCR_LD_IDLE, cnt: 8'h00, busy: 1'b0, done: 1'b0};
        end else begin
            r <= next_r;
        end
    end

    assign busy = r.busy;
    assign done = r.done;
endmodule : vcr_table_loader

/* hw/vcr_preload.sv */
// eeprom preload capture for the traffic-class map and time slot defaults
`timescale 1ns/1ps
module vcr_preload (
    input  wire logic                     mclk,
    input  wire logic                     rst_n,
    input  wire logic                     ee_tc_map_valid,
    input  wire logic [vcr_pkg::TCMAP_W-1:0] ee_tc_map,
    input  wire logic                     ee_mts_valid,
    input  wire logic [vcr_pkg::MTS_W-1:0] ee_mts,
    input  wire logic                     ee_done,
    output logic                          tc_apply,
    output logic [vcr_pkg::TCMAP_W-1:0]   tc_val,
    output logic                          mts_apply,
    output logic [vcr_pkg::MTS_W-1:0]     mts_val,
    output logic                          ready
);
    import vcr_pkg::*;

    typedef struct packed {
        logic               tc_apply;
        logic [TCMAP_W-1:0] tc_val;
        logic               mts_apply;
        logic [MTS_W-1:0]   mts_val;
        logic               ready;
    } vcr_pl_s;

    vcr_pl_s r;
    vcr_pl_s next_r;

    always_comb begin
        next_r           = r;
        next_r.tc_apply  = 1'b0;
        next_r.mts_apply = 1'b0;
        if (!r.ready) begin
            if (ee_tc_map_valid) begin
                next_r.tc_apply = 1'b1;
                next_r.tc_val   = ee_tc_map;
            end
            if (ee_mts_valid) begin
                next_r.mts_apply = 1'b1;
                next_r.mts_val   = ee_mts;
            end
            if (ee_done) begin
                next_r.ready = 1'b1;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            r <= '{tc_apply: 1'b0, tc_val: TCMAP_RST, mts_apply: 1'b0, mts_val: MTS_RST, ready: 1'b0};
        end else begin
            r <= next_r;
        end
    end

    assign tc_apply  = r.tc_apply;
    assign tc_val    = r.tc_val;
    assign mts_apply = r.mts_apply;
    assign mts_val   = r.mts_val;
    assign ready     = r.ready;
endmodule : vcr_preload

/* hw/vcr_regs.sv */
// vc0 resource register bank on apb
// Operation
// RULE1: writing any vc arbitration table entry sets read-only status bit 16; resets zero.
// RULE2: status bit 16 clears when hardware finishes loading the vc arbitration table.
// RULE3: writing one to port vc bit 0 loads vc table; always reads zero.
// RULE4: port arbitration capability bits 7:0 read-only, value 09h.
// RULE5: time-based weighted round-robin is never advertised on vc0.
// RULE6: advanced packet switching bit 14 read-only, reads zero.
// RULE7: reject snoop bit 15 read-only, reads zero.
// RULE8: maximum time slots bits 22:16 read-only, reset 7Fh, eeprom may override.
// RULE9: port arbitration table offset bits 31:24 read-only, value 04h.
// RULE10: traffic-class map bits 7:0 writable, reset FFh, eeprom may override.
// RULE11: writing one to control bit 16 loads port table; always reads zero.
// RULE12: select bits 19:17 accept 000b or 011b, else default; reset 000b.
// RULE13: channel id bits 26:24 read-only, fixed 000b.
// RULE14: enable bit 31 writable, reset one.
// RULE15: read-only writes ignored; reserved bits read zero.
// RULE16: eeprom defaults applied before software may access registers.
`timescale 1ns/1ps
module vcr_regs #(
    parameter int LOAD_CYCLES = vcr_pkg::LOAD_CYCLES
) (
    input  wire logic                       mclk,
    input  wire logic                       rst_n,
    input  wire logic                       psel,
    input  wire logic                       penable,
    input  wire logic                       pwrite,
    input  wire logic [vcr_pkg::ADDR_W-1:0] paddr,
    input  wire logic [vcr_pkg::DATA_W-1:0] pwdata,
    input  wire logic [3:0]                 pstrb,
    output logic [vcr_pkg::DATA_W-1:0]      prdata,
    output logic                            pready,
    output logic                            pslverr,
    input  wire logic                       vc_tbl_wr,
    input  wire logic                       pa_tbl_wr,
    input  wire logic                       ee_tc_map_valid,
    input  wire logic [vcr_pkg::TCMAP_W-1:0] ee_tc_map,
    input  wire logic                       ee_mts_valid,
    input  wire logic [vcr_pkg::MTS_W-1:0]  ee_mts,
    input  wire logic                       ee_done,
    output logic                            vc_tbl_loading,
    output logic                            pa_tbl_loading,
    output logic                            pa_tbl_dirty,
    output logic [vcr_pkg::TCMAP_W-1:0]     tc_map,
    output logic [vcr_pkg::PASEL_W-1:0]     pa_sel,
    output logic [vcr_pkg::VCSEL_W-1:0]     vc_arb_sel,
    output logic                            vc_enable
);
    import vcr_pkg::*;

    if (LOAD_CYCLES < 1 || LOAD_CYCLES > 255) begin : g_chk
        $error("vcr_regs: LOAD_CYCLES out of range");
    end

    typedef struct packed {
        logic [DATA_W-1:0]  prdata;
        logic               pready;
        logic               pslverr;
        logic               vc_stat;
        logic               pa_dirty;
        logic               vc_load;
        logic               pa_load;
        logic [VCSEL_W-1:0] vc_sel;
        logic [TCMAP_W-1:0] tc_map;
        logic [MTS_W-1:0]   mts;
        logic [PASEL_W-1:0] pa_sel;
        logic               vc_en;
    } vcr_rg_s;

    vcr_rg_s r;
    vcr_rg_s next_r;

    logic               vc_busy;
    logic               vc_done;
    logic               pa_busy;
    logic               pa_done;
    logic               pl_tc_apply;
    logic [TCMAP_W-1:0] pl_tc_val;
    logic               pl_mts_apply;
    logic [MTS_W-1:0]   pl_mts_val;
    logic               pl_ready;

    vcr_table_loader #(
        .CYCLES (LOAD_CYCLES)
    ) u_vc_loader (
        .mclk  (mclk),
        .rst_n (rst_n),
        .start (r.vc_load),
        .busy  (vc_busy),
        .done  (vc_done)
    );

    vcr_table_loader #(
        .CYCLES (LOAD_CYCLES)
    ) u_pa_loader (
        .mclk  (mclk),
        .rst_n (rst_n),
        .start (r.pa_load),
        .busy  (pa_busy),
        .done  (pa_done)
    );

    vcr_preload u_preload (
        .mclk            (mclk),
        .rst_n           (rst_n),
        .ee_tc_map_valid (ee_tc_map_valid),
        .ee_tc_map       (ee_tc_map),
        .ee_mts_valid    (ee_mts_valid),
        .ee_mts          (ee_mts),
        .ee_done         (ee_done),
        .tc_apply        (pl_tc_apply),
        .tc_val          (pl_tc_val),
        .mts_apply       (pl_mts_apply),
        .mts_val         (pl_mts_val),
        .ready           (pl_ready)
    );

    // byte-lane write mask
    function automatic logic [DATA_W-1:0] lane_mask(input logic [3:0] strb);
        logic [DATA_W-1:0] m;
        m = '0;
        for (int i = 0; i < 4; i++) begin
            m[i*8 +: 8] = {8{strb[i]}};
        end
        return m;
    endfunction : lane_mask

    // read images
    function automatic logic [DATA_W-1:0] port_vc_word(input vcr_rg_s s);
        logic [DATA_W-1:0] w;
        w = '0;
        w[VCSEL_LSB +: VCSEL_W] = s.vc_sel;
        w[VCSTAT_BIT]           = s.vc_stat;
        return w;
    endfunction : port_vc_word

    function automatic logic [DATA_W-1:0] cap0_word(input vcr_rg_s s);
        logic [DATA_W-1:0] w;
        w = '0;
        w[PACAP_LSB +: 8]        = PACAP_RST;
        w[APS_BIT]               = 1'b0;
        w[RSNOOP_BIT]            = 1'b0;
        w[MTS_LSB +: MTS_W]      = s.mts;
        w[PATOFF_LSB +: 8]       = PATOFF_RST;
        return w;
    endfunction : cap0_word

    function automatic logic [DATA_W-1:0] ctl0_word(input vcr_rg_s s);
        logic [DATA_W-1:0] w;
        w = '0;
        w[TCMAP_LSB +: TCMAP_W] = s.tc_map;
        w[PASEL_LSB +: PASEL_W] = s.pa_sel;
        w[VCID_LSB +: 3]        = VCID_RST;
        w[VCEN_BIT]             = s.vc_en;
        return w;
    endfunction : ctl0_word

    logic              acc;
    logic              done_xfer;
    logic              hit;
    logic [DATA_W-1:0] rdat;
    logic [DATA_W-1:0] m;
    logic [DATA_W-1:0] wv;
    logic [2:0]        sel_w;

    always_comb begin
        next_r         = r;
        next_r.vc_load = 1'b0;
        next_r.pa_load = 1'b0;
        acc            = psel && penable && !r.pready && pl_ready && !pl_tc_apply && !pl_mts_apply; // RULE16
        done_xfer      = psel && penable && r.pready;
        m              = lane_mask(pstrb);
        hit            = 1'b1;
        rdat           = '0;
        wv             = '0;
        sel_w          = '0;
        case (paddr)
            OFF_PORT_VC: rdat = port_vc_word(r); // RULE3
            OFF_CAP0:    rdat = cap0_word(r); // RULE4 RULE5 RULE6 RULE7 RULE9
            OFF_CTL0:    rdat = ctl0_word(r); // RULE11 RULE13
            default:     hit  = 1'b0;
        endcase

        // preload ahead of any software access
        if (pl_tc_apply) begin
            next_r.tc_map = pl_tc_val; // RULE10 RULE16
        end
        if (pl_mts_apply) begin
            next_r.mts = pl_mts_val; // RULE8 RULE16
        end

        // apb answer one cycle into the access phase
        if (acc) begin
            next_r.pready  = 1'b1;
            next_r.pslverr = !hit;
            next_r.prdata  = pwrite ? '0 : rdat;
        end
        if (done_xfer) begin
            next_r.pready  = 1'b0;
            next_r.pslverr = 1'b0;
        end

        // register writes commit at the completing edge
        if (done_xfer && pwrite && hit) begin
            case (paddr)
                OFF_PORT_VC: begin
                    wv = (port_vc_word(r) & ~m) | (pwdata & m);
                    if (m[VCLOAD_BIT] && pwdata[VCLOAD_BIT]) begin
                        next_r.vc_load = 1'b1; // RULE3
                    end
                    sel_w = wv[VCSEL_LSB +: VCSEL_W];
                    next_r.vc_sel = (sel_w <= VCSEL_MAX_OK) ? sel_w : VCSEL_RST;
                end
                OFF_CTL0: begin
                    wv = (ctl0_word(r) & ~m) | (pwdata & m);
                    next_r.tc_map = wv[TCMAP_LSB +: TCMAP_W]; // RULE10
                    if (m[PALOAD_BIT] && pwdata[PALOAD_BIT]) begin
                        next_r.pa_load = 1'b1; // RULE11
                    end
                    sel_w = wv[PASEL_LSB +: PASEL_W];
                    if (sel_w == PASEL_WRR128) begin
                        next_r.pa_sel = PASEL_WRR128; // RULE12
                    end else begin
                        next_r.pa_sel = PASEL_RR; // RULE12
                    end
                    next_r.vc_en = wv[VCEN_BIT]; // RULE14
                end
                default: begin
                    wv = '0; // RULE15
                end
            endcase
        end

        // table status: a new entry write wins over load completion
        if (vc_done) begin
            next_r.vc_stat = 1'b0; // RULE2
        end
        if (vc_tbl_wr) begin
            next_r.vc_stat = 1'b1; // RULE1
        end
        if (pa_done) begin
            next_r.pa_dirty = 1'b0;
        end
        if (pa_tbl_wr) begin
            next_r.pa_dirty = 1'b1;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            r <= '{
                prdata:   '0,
                pready:   1'b0,
                pslverr:  1'b0,
                vc_stat:  1'b0,
                pa_dirty: 1'b0,
                vc_load:  1'b0,
                pa_load:  1'b0,
                vc_sel:   VCSEL_RST,
                tc_map:   TCMAP_RST,
                mts:      MTS_RST,
                pa_sel:   PASEL_RR,
                vc_en:    VCEN_RST
            };
        end else begin
            r <= next_r;
        end
    end

    assign prdata         = r.prdata;
    assign pready         = r.pready;
    assign pslverr        = r.pslverr;
    assign vc_tbl_loading = vc_busy;
    assign pa_tbl_loading = pa_busy;
    assign pa_tbl_dirty   = r.pa_dirty;
    assign tc_map         = r.tc_map;
    assign pa_sel         = r.pa_sel;
    assign vc_arb_sel     = r.vc_sel;
    assign vc_enable      = r.vc_en;
endmodule : vcr_regs

/* testbench/vcr_regs_sva.sv */
// checker: apb timing and field values of the vc0 resource register bank
`timescale 1ns/1ps
module vcr_regs_sva
    import vcr_pkg::*;
#(
    parameter int LOAD_CYCLES = 8
) (
    input wire logic                       mclk,
    input wire logic                       rst_n,
    input wire logic                       psel,
    input wire logic                       penable,
    input wire logic                       pwrite,
    input wire logic [vcr_pkg::ADDR_W-1:0] paddr,
    input wire logic [vcr_pkg::DATA_W-1:0] prdata,
    input wire logic                       pready,
    input wire logic                       pslverr,
    input wire logic                       vc_tbl_loading,
    input wire logic [vcr_pkg::TCMAP_W-1:0] tc_map,
    input wire logic [vcr_pkg::PASEL_W-1:0] pa_sel,
    input wire logic                       vc_enable
);
    logic       rd;
    logic [7:0] ld_cnt;
    assign rd = pready && !pwrite;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    // cycles the table load has been running
    always_ff @(posedge mclk) begin
        if (!rst_n || !vc_tbl_loading) begin
            ld_cnt <= 8'h0;
        end else begin
            ld_cnt <= ld_cnt + 8'h1;
        end
    end
    a_pready_single: assert property (pready |=> !pready)
        else $error("pready high longer than one cycle");
    a_pready_wait: assert property (pready |-> psel && penable && $past(psel && penable))
        else $error("pready without a waited access phase");
    a_err_unmapped: assert property (pready |-> pslverr == !(paddr == OFF_PORT_VC || paddr == OFF_CAP0 || paddr == OFF_CTL0))
        else $error("pslverr does not match address decode");
    a_cap_fixed: assert property (rd && paddr == OFF_CAP0 |-> prdata[15:0] == 16'h0009 && prdata[31:23] == 9'h008)
        else $error("capability fixed fields wrong");
    a_ctl_fixed: assert property (rd && paddr == OFF_CTL0 |-> prdata[30:20] == 11'h0 && prdata[16:8] == 9'h0)
        else $error("control fixed fields not zero");
    a_ctl_mirror: assert property (rd && paddr == OFF_CTL0 |-> prdata[7:0] == tc_map && prdata[19:17] == pa_sel && prdata[31] == vc_enable)
        else $error("control readback differs from outputs");
    a_port_vc_zero: assert property (rd && paddr == OFF_PORT_VC |-> !prdata[0] && prdata[15:4] == 12'h0 && prdata[31:17] == 15'h0)
        else $error("port vc word nonzero field");
    a_pasel_legal: assert property (pa_sel == PASEL_RR || pa_sel == PASEL_WRR128)
        else $error("illegal port arbitration select");
    a_vc_load_len: assert property ($fell(vc_tbl_loading) |-> ld_cnt == LOAD_CYCLES)
        else $error("table load length wrong");
    c_cap_read: cover property (rd && paddr == OFF_CAP0);
    c_ctl_write: cover property (pready && pwrite && paddr == OFF_CTL0);
    c_vc_load: cover property ($fell(vc_tbl_loading));
    c_unmapped: cover property (pready && pslverr);
endmodule : vcr_regs_sva

/* testbench/vcr_regs_tb_top.sv */
// testbench: directed apb scenarios for the vc0 resource register bank
`timescale 1ns/1ps
module vcr_regs_tb_top;
    import vcr_pkg::*;
    localparam int LC = 2;
    logic        mclk, rst_n, psel, penable, pwrite, pready, pslverr, vc_tbl_wr, pa_tbl_wr, rerr;
    logic        ee_tc_map_valid, ee_mts_valid, ee_done, vc_tbl_loading, pa_tbl_loading, pa_tbl_dirty, vc_enable;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rdat;
    logic [3:0]  pstrb;
    logic [7:0]  ee_tc_map, tc_map;
    logic [6:0]  ee_mts;
    logic [2:0]  pa_sel, vc_arb_sel;
    int          miscompares, checks;

    vcr_regs #(.LOAD_CYCLES(LC)) dut_u (
        .mclk(mclk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .vc_tbl_wr(vc_tbl_wr), .pa_tbl_wr(pa_tbl_wr), .ee_tc_map_valid(ee_tc_map_valid), .ee_tc_map(ee_tc_map),
        .ee_mts_valid(ee_mts_valid), .ee_mts(ee_mts), .ee_done(ee_done), .vc_tbl_loading(vc_tbl_loading),
        .pa_tbl_loading(pa_tbl_loading), .pa_tbl_dirty(pa_tbl_dirty), .tc_map(tc_map), .pa_sel(pa_sel),
        .vc_arb_sel(vc_arb_sel), .vc_enable(vc_enable)
    );

    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end

    task automatic close_out;
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : close_out

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            miscompares++;
            $display("unexpected %s: expected %h seen %h", nm, e, g);
        end
    endtask : chk

    // one apb transfer; holds the request until pready is sampled high
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
        int n;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge mclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (pready !== 1'b1 && n < 40);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 40) chk("pready", 32'h1, 32'h0);
        @(posedge mclk);
    endtask : apb

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 4'hf);
    endtask : wr

    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0, 4'hf);
        chk("prdata", e, rdat);
    endtask : rd

    // waits for a table load that was just committed to run and finish
    task automatic wait_idle(input logic [1:0] e);
        int n;
        repeat (2) @(posedge mclk);
        chk("loading", {30'h0, e}, {30'h0, pa_tbl_loading, vc_tbl_loading});
        n = 0;
        while ((vc_tbl_loading | pa_tbl_loading) !== 1'b0 && n < 40) begin
            @(posedge mclk);
            n++;
        end
        chk("loading", 32'h0, {31'h0, vc_tbl_loading | pa_tbl_loading});
    endtask : wait_idle

    task automatic t_preload;
        fork
            rd(OFF_CAP0, 32'h04150009);
            begin
                repeat (6) @(posedge mclk);
                chk("pready", 32'h0, {31'h0, pready});
                ee_tc_map_valid <= 1'b1;
                ee_tc_map <= 8'h5a;
                ee_mts_valid <= 1'b1;
                ee_mts <= 7'h15;
                @(posedge mclk);
                ee_tc_map_valid <= 1'b0;
                ee_mts_valid <= 1'b0;
                ee_done <= 1'b1;
            end
        join
        rd(OFF_CTL0, 32'h8000005a);
        $display("test preload done");
    endtask : t_preload

    task automatic t_ctl;
        wr(OFF_CAP0, 32'hffffffff);
        rd(OFF_CAP0, 32'h04150009);
        wr(OFF_CTL0, 32'h7ff6ffa5);
        rd(OFF_CTL0, 32'h000600a5);
        chk("tc_map", 32'ha5, {24'h0, tc_map});
        chk("vc_enable", 32'h0, {31'h0, vc_enable});
        for (int i = 0; i < 8; i++) begin
            wr(OFF_CTL0, {1'b1, 11'h0, i[2:0], 1'b0, 16'h003c});
            rd(OFF_CTL0, {1'b1, 11'h0, (i == 3) ? 3'h3 : 3'h0, 17'h0003c});
            chk("pa_sel", (i == 3) ? 32'h3 : 32'h0, {29'h0, pa_sel});
        end
        apb(1'b1, OFF_CTL0, 32'h0, 4'h8);
        rd(OFF_CTL0, 32'h0000003c);
        $display("test control done");
    endtask : t_ctl

    task automatic t_vc;
        vc_tbl_wr <= 1'b1;
        @(posedge mclk);
        vc_tbl_wr <= 1'b0;
        @(posedge mclk);
        rd(OFF_PORT_VC, 32'h00010000);
        wr(OFF_PORT_VC, 32'h00000003);
        wait_idle(2'b01);
        rd(OFF_PORT_VC, 32'h00000002);
        chk("vc_arb_sel", 32'h1, {29'h0, vc_arb_sel});
        wr(OFF_PORT_VC, 32'hfffffffe);
        rd(OFF_PORT_VC, 32'h0);
        $display("test vc table done");
    endtask : t_vc

    task automatic t_pa;
        pa_tbl_wr <= 1'b1;
        @(posedge mclk);
        pa_tbl_wr <= 1'b0;
        @(posedge mclk);
        chk("pa_tbl_dirty", 32'h1, {31'h0, pa_tbl_dirty});
        wr(OFF_CTL0, 32'h80010000);
        wait_idle(2'b10);
        @(posedge mclk);
        chk("pa_tbl_dirty", 32'h0, {31'h0, pa_tbl_dirty});
        rd(OFF_CTL0, 32'h80000000);
        rd(12'h158, 32'h0);
        chk("pslverr", 32'h1, {31'h0, rerr});
        $display("test port table done");
    endtask : t_pa

    task automatic t_rst2;
        rst_n <= 1'b0;
        repeat (3) @(posedge mclk);
        rst_n <= 1'b1;
        @(posedge mclk);
        rd(OFF_CAP0, 32'h047f0009);
        rd(OFF_CTL0, 32'h800000ff);
        $display("test second reset done");
    endtask : t_rst2

    initial begin
        {rst_n, psel, penable, pwrite, vc_tbl_wr, pa_tbl_wr} = 6'h0;
        {ee_tc_map_valid, ee_mts_valid, ee_done, ee_tc_map, ee_mts} = 18'h0;
        {paddr, pwdata, pstrb} = 48'h0;
        miscompares = 0;
        checks = 0;
        repeat (10) @(posedge mclk);
        rst_n <= 1'b1;
        @(posedge mclk);
        t_preload();
        t_ctl();
        t_vc();
        t_pa();
        t_rst2();
        close_out();
    end

    initial begin
        repeat (5000) @(posedge mclk);
        miscompares++;
        close_out();
    end
endmodule : vcr_regs_tb_top

bind vcr_regs vcr_regs_sva #(.LOAD_CYCLES(LOAD_CYCLES)) u_sva (
    .mclk(mclk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .vc_tbl_loading(vc_tbl_loading),
    .tc_map(tc_map), .pa_sel(pa_sel), .vc_enable(vc_enable)
);
